// File: logic/ros_params.svh
// Constants for the remappable output select bank: offsets, field positions, resets.
// Assumes inclusion by bare name from any file that needs them.
`ifndef ROS_PARAMS_SVH
`define ROS_PARAMS_SVH

`define ROS_ADDR_W        4
`define ROS_OFF_PINS_8_9  4'h0
`define ROS_OFF_PINS_10_11 4'h1
`define ROS_OFF_PINS_12_13 4'h2
`define ROS_OFF_PINS_14_15 4'h3
`define ROS_OFF_PINS_16_17 4'h4
`define ROS_REG_COUNT     5
`define ROS_ODD_LSB       8
`define ROS_EVEN_LSB      0
`define ROS_SEL_W         6
`define ROS_SEL_RESET     6'h00
`define ROS_DATA_W        16
`define ROS_FIRST_PIN     8

`endif

// File: logic/ros_pkg.sv
// Types shared by the remappable output select bank.
// Assumes ros_params.svh sits beside it.
`include "ros_params.svh"
package ros_pkg;
  typedef logic [`ROS_SEL_W-1:0]  ros_sel_t;
  typedef logic [`ROS_DATA_W-1:0] ros_word_t;
endpackage

// File: logic/ros_pin_mux.sv
// One remappable pin: picks a peripheral output by its number.
// Assumes the selector is registered upstream; output is registered here.
`timescale 1ns/100ps
module ros_pin_mux
  import ros_pkg::*;
#(
  parameter int NUM_FUNCS = 64
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire ros_sel_t             sel,
  input  wire logic [NUM_FUNCS-1:0] periph_out,
  output logic                      pin_out
);

  logic next_pin_out;

  // Selector zero and out-of-range numbers leave the pin low.
  always_comb begin
    next_pin_out = 1'b0;
    if (sel != '0 && int'(sel) < NUM_FUNCS) begin
      next_pin_out = periph_out[sel];
    end
  end

  // Registered so the top output comes straight from a flip-flop.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
    end
  end

endmodule

// File: logic/ros_bank.sv
// Remappable output select bank for pins 8 to 17: five selector registers.
// Assumes a plain register port; synchronous peripheral outputs.
`timescale 1ns/100ps
`include "ros_params.svh"
module ros_bank
  import ros_pkg::*;
#(
  parameter int NUM_FUNCS   = 64,
  parameter bit SMALL_PKG   = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic [`ROS_ADDR_W-1:0] reg_addr,
  input  wire ros_word_t              reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output ros_word_t                   reg_rdata,
  input  wire logic [NUM_FUNCS-1:0]   periph_out,
  output logic [9:0]                  remap_pin_out,
  output ros_sel_t                    pin8_output_selector,
  output ros_sel_t                    pin9_output_selector,
  output ros_sel_t                    pin10_output_selector,
  output ros_sel_t                    pin11_output_selector,
  output ros_sel_t                    pin12_output_selector,
  output ros_sel_t                    pin13_output_selector,
  output ros_sel_t                    pin14_output_selector,
  output ros_sel_t                    pin15_output_selector,
  output ros_sel_t                    pin16_output_selector,
  output ros_sel_t                    pin17_output_selector
);

  ////////////////////////////////////////////////////////////////////////////
  // Selector storage: index 0 is pin 8, index 9 is pin 17.

  ros_sel_t  sel      [10];
  ros_sel_t  next_sel [10];
  ros_word_t next_reg_rdata;

  // Packs a pin pair into one bus word with unused bits at zero.
  function automatic ros_word_t ros_pack(input ros_sel_t odd_sel, input ros_sel_t even_sel);
    ros_word_t w;
    w = '0;
    w[`ROS_ODD_LSB +: `ROS_SEL_W]  = odd_sel;
    w[`ROS_EVEN_LSB +: `ROS_SEL_W] = even_sel;
    return w;
  endfunction

  // True when the address hits a mapped register.
  function automatic logic ros_hit(input logic [`ROS_ADDR_W-1:0] a);
    return int'(a) < `ROS_REG_COUNT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write path: only the two fields are stored; the other bits are dropped.
  always_comb begin
    int idx;
    idx = int'(reg_addr);
    for (int i = 0; i < 10; i++) begin
      next_sel[i] = sel[i];
    end
    if (reg_wr && ros_hit(reg_addr)) begin
      next_sel[2*idx]   = reg_wdata[`ROS_EVEN_LSB +: `ROS_SEL_W];
      next_sel[2*idx+1] = reg_wdata[`ROS_ODD_LSB +: `ROS_SEL_W];
    end
    // Pin 15 has no storage in the small package, so it stays at zero.
    if (SMALL_PKG) begin
      next_sel[15-`ROS_FIRST_PIN] = `ROS_SEL_RESET;
    end
  end

  // Reset clears every selector; no enable gates the new value.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 10; i++) begin
        sel[i] <= `ROS_SEL_RESET;
      end
    end else begin
      for (int i = 0; i < 10; i++) begin
        sel[i] <= next_sel[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data stand in the cycle after the strobe; unmapped reads zero.
  always_comb begin
    int idx;
    idx = int'(reg_addr);
    next_reg_rdata = '0;
    if (reg_rd && ros_hit(reg_addr)) begin
      next_reg_rdata = ros_pack(sel[2*idx+1], sel[2*idx]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selector views for the rest of the chip, straight from the flip-flops.
  assign pin8_output_selector  = sel[0];
  assign pin9_output_selector  = sel[1];
  assign pin10_output_selector = sel[2];
  assign pin11_output_selector = sel[3];
  assign pin12_output_selector = sel[4];
  assign pin13_output_selector = sel[5];
  assign pin14_output_selector = sel[6];
  assign pin15_output_selector = sel[7];
  assign pin16_output_selector = sel[8];
  assign pin17_output_selector = sel[9];

  ////////////////////////////////////////////////////////////////////////////
  // One multiplexer per pin; the pin follows a write two edges after the strobe.
  for (genvar g = 0; g < 10; g++) begin : g_pin
    ros_pin_mux #(
      .NUM_FUNCS (NUM_FUNCS)
    ) u_mux (
      .clk        (clk),
      .rst_b      (rst_b),
      .sel        (sel[g]),
      .periph_out (periph_out),
      .pin_out    (remap_pin_out[g])
    );
  end

endmodule

// File: dv/ros_bank_chk.sv
// Checker of the output select bank: register, reset and routing relations.
// Assumes a bind to ros_bank and a single clock domain.
`timescale 1ns/100ps
`include "ros_params.svh"
module ros_bank_chk
  import ros_pkg::*;
#(
  parameter int NUM_FUNCS = 64,
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic [`ROS_ADDR_W-1:0] reg_addr,
  input wire ros_word_t              reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire ros_word_t              reg_rdata,
  input wire logic [NUM_FUNCS-1:0]   periph_out,
  input wire logic [9:0]             remap_pin_out,
  input wire ros_sel_t               pin8_output_selector,
  input wire ros_sel_t               pin9_output_selector,
  input wire ros_sel_t               pin15_output_selector
);
  ////////////////////////////////////////////////////////////////////
  // Short aliases keep the properties on one line each, all but p_route.
  wire ros_sel_t s8 = pin8_output_selector;
  wire ros_sel_t s9 = pin9_output_selector;
  wire           w0 = reg_wr && reg_addr == 4'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_even; w0 |=> s8 == $past(reg_wdata[5:0]); endproperty
  property p_odd; w0 |=> s9 == $past(reg_wdata[13:8]); endproperty
  property p_hold; !w0 |=> $stable(s8); endproperty
  property p_back; reg_rd && reg_addr == 4'h0 |=> reg_rdata == {2'h0, s9, 2'h0, s8}; endproperty
  property p_unmap; reg_rd && reg_addr > 4'h4 |=> reg_rdata == 16'h0000; endproperty
  property p_small; SMALL_PKG |-> pin15_output_selector == 6'h00; endproperty
  property p_reset; $rose(rst_b) |-> s8 == 6'h00 && s9 == 6'h00; endproperty
  property p_route;
    1'b1 |=> remap_pin_out[0] == ($past(s8 != 6'h00) && $past(periph_out[s8]));
  endproperty
  a_even: assert property (p_even) else $error("pin 8 selector missed a write");
  a_odd: assert property (p_odd) else $error("pin 9 selector missed a write");
  a_hold: assert property (p_hold) else $error("pin 8 selector moved unasked");
  a_back: assert property (p_back) else $error("readback differs from fields");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_small: assert property (p_small) else $error("pin 15 selector not zero");
  a_reset: assert property (p_reset) else $error("selector not clear after reset");
  a_route: assert property (p_route) else $error("pin 8 routed wrongly");
  c_wr: cover property (w0);
  c_unmap: cover property (reg_rd && reg_addr > 4'h4);
  c_pin: cover property (remap_pin_out[0]);
endmodule

// File: dv/ros_bank_bench.sv
// Bench of the output select bank: random register traffic against a model.
// Assumes the design files compile first; the checker is bound at the foot.
`timescale 1ns/100ps
module ros_bank_bench
  import ros_pkg::*;
;
  localparam bit SP = 1'b1;
  logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  ros_word_t   reg_wdata = 16'h0000, reg_rdata;
  logic [63:0] periph_out = 64'h0;
  logic [9:0]  remap_pin_out;
  int          m [5] = '{0, 0, 0, 0, 0};
  ros_sel_t    so [10];
  int          n_errors = 0, samples_checked = 0, seed = 82;
  ros_bank #(.SMALL_PKG(SP)) dut_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .periph_out, .remap_pin_out, .pin8_output_selector(so[0]),
    .pin9_output_selector(so[1]), .pin10_output_selector(so[2]), .pin11_output_selector(so[3]),
    .pin12_output_selector(so[4]), .pin13_output_selector(so[5]),
    .pin14_output_selector(so[6]), .pin15_output_selector(so[7]),
    .pin16_output_selector(so[8]), .pin17_output_selector(so[9]));
  ////////////////////////////////////////////////////////////////////
  // Free-running clock; watchdog cuts a hang far beyond the expected run.
  always #5 clk = ~clk;
  initial begin
    #100000 n_errors++;
    report_and_stop();
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Model drops the empty bit positions, and pin 15 in the small package.
  task automatic wr(input int a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a[3:0];
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a < 5) m[a] = d & ((SP && a == 3) ? 16'h003F : 16'h3F3F);
  endtask
  task automatic rd(input int a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a[3:0];
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, (a < 5) ? m[a][15:0] : 16'h0000);
  endtask
  // Peripherals held steady long enough for the registered pins to settle.
  task automatic pins();
    int   f;
    logic e;
    @(posedge clk);
    periph_out <= {$random(seed), $random(seed)};
    repeat (3) @(posedge clk);
    #1;
    for (int k = 0; k < 10; k++) begin
      f = (k % 2) ? m[k / 2][13:8] : m[k / 2][5:0];
      e = (f != 0) && periph_out[f];
      chk({15'h0000, remap_pin_out[k]}, {15'h0000, e});
      chk({10'h000, so[k]}, {10'h000, f[5:0]});
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Reset, clear-state reads, all-ones writes, then random traffic.
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 6; a++) rd(a);
    $display("reset test done");
    for (int a = 0; a < 5; a++) wr(a, 16'hFFFF);
    for (int a = 0; a < 6; a++) rd(a);
    pins();
    $display("all ones test done");
    repeat (40) begin
      wr($random(seed) & 7, 16'($random(seed)));
      rd($random(seed) & 7);
      pins();
    end
    $display("random test done");
    report_and_stop();
  end
endmodule
bind ros_bank ros_bank_chk #(.NUM_FUNCS(NUM_FUNCS), .SMALL_PKG(SMALL_PKG)) chk_u (.clk,
  .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_out, .remap_pin_out,
  .pin8_output_selector, .pin9_output_selector, .pin15_output_selector);
